// ---- design/sxd_pkg.sv ----
package sxd_pkg;
  localparam int DATA_W = 32;
  localparam int NUM_GPR = 8;
  localparam logic [31:0] SP_RESET = 32'h0000_0000;
  localparam logic [31:0] STEP_DWORD = 32'h0000_0004;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [2:0] GPR_ACC = 3'h0;
  localparam logic [2:0] GPR_CNT = 3'h1;
  localparam logic [2:0] GPR_DAT = 3'h2;
  localparam logic [2:0] GPR_BAS = 3'h3;
  localparam logic [2:0] GPR_STK = 3'h4;
  localparam logic [2:0] GPR_FRM = 3'h5;
  localparam logic [2:0] GPR_SRC = 3'h6;
  localparam logic [2:0] GPR_DST = 3'h7;
  localparam logic [2:0] SLOT_LAST = 3'h7;
  localparam int DIV_CYCLES = 32;
  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
  localparam logic [7:0] BCD_HIGH_LIM = 8'h99;
  localparam logic [3:0] BCD_DIGIT_LIM = 4'h9;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_DWORD = 2'h2
  } sxd_size_t;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_PUSH = 5'h01,
    OP_POP = 5'h02,
    OP_PUSHALL = 5'h03,
    OP_POPALL = 5'h04,
    OP_CBW = 5'h05,
    OP_WORD_TO_DWORD_EXT = 5'h06,
    OP_CWDPAIR = 5'h07,
    OP_CDQPAIR = 5'h08,
    OP_MOVSEXT = 5'h09,
    OP_MOVZEXT = 5'h0A,
    OP_ADD = 5'h0B,
    OP_ADC = 5'h0C,
    OP_SUB = 5'h0D,
    OP_SBB = 5'h0E,
    OP_INC = 5'h0F,
    OP_DEC = 5'h10,
    OP_CMP = 5'h11,
    OP_NEG = 5'h12,
    OP_UMUL = 5'h13,
    OP_SMUL = 5'h14,
    OP_UDIV = 5'h15,
    OP_SDIV = 5'h16,
    OP_BCDADD = 5'h17,
    OP_BCDSUB = 5'h18
  } sxd_op_t;

  typedef struct packed {
    sxd_op_t op;
    sxd_size_t size;
    sxd_size_t srcSize;
    logic addr32;
    logic truncMul;
    logic [2:0] dstSel;
    logic [31:0] opA;
    logic [31:0] opB;
  } sxd_req_t;

  typedef struct packed {
    logic carry;
    logic parity;
    logic auxCarry;
    logic zero;
    logic sign;
    logic overflow;
  } sxd_flags_t;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [31:0] addr;
    logic [31:0] wrData;
  } sxd_mem_t;
endpackage : sxd_pkg

// ---- design/sxd_divider.sv ----
`timescale 1ns/1ps
module sxd_divider #(
  parameter int WIDTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic signedMode,
  input wire logic [2*WIDTH-1:0] dividend,
  input wire logic [WIDTH-1:0] divisor,
  output logic busy,
  output logic done,
  output logic [WIDTH-1:0] quotient,
  output logic [WIDTH-1:0] remainder
);
  logic [2*WIDTH-1:0] num_reg;
  logic [WIDTH:0] rem_reg;
  logic [WIDTH-1:0] den_reg;
  logic [7:0] cnt_reg;
  logic negQ_reg;
  logic negR_reg;
  logic [WIDTH:0] trial;

  // Shift-subtract on magnitudes; signs restored at the end
  assign trial = {rem_reg[WIDTH-1:0], num_reg[2*WIDTH-1]} - {1'b0, den_reg};

  always_ff @(posedge clk_sys)
  begin
    done <= 1'b0;
    if (rst)
    begin
      busy <= 1'b0;
      cnt_reg <= 8'h00;
      num_reg <= '0;
      rem_reg <= '0;
      den_reg <= '0;
      negQ_reg <= 1'b0;
      negR_reg <= 1'b0;
      quotient <= '0;
      remainder <= '0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      cnt_reg <= 8'(2 * WIDTH);
      rem_reg <= '0;
      negR_reg <= signedMode && dividend[2*WIDTH-1];
      negQ_reg <= signedMode && (dividend[2*WIDTH-1] ^ divisor[WIDTH-1]);
      num_reg <= (signedMode && dividend[2*WIDTH-1]) ? -dividend : dividend;
      den_reg <= (signedMode && divisor[WIDTH-1]) ? -divisor : divisor;
    end
    else if (busy)
    begin
      if (!trial[WIDTH])
      begin
        rem_reg <= trial;
        num_reg <= {num_reg[2*WIDTH-2:0], 1'b1};
      end
      else
      begin
        rem_reg <= {rem_reg[WIDTH-1:0], num_reg[2*WIDTH-1]};
        num_reg <= {num_reg[2*WIDTH-2:0], 1'b0};
      end
      cnt_reg <= cnt_reg - 8'h01;
      if (cnt_reg == 8'h01)
      begin
        busy <= 1'b0;
        done <= 1'b1;
        // Final shift value computed here since num_reg updates late
        if (!trial[WIDTH])
        begin
          quotient <= negQ_reg ? -{num_reg[WIDTH-2:0], 1'b1}
                               : {num_reg[WIDTH-2:0], 1'b1};
          remainder <= negR_reg ? -trial[WIDTH-1:0] : trial[WIDTH-1:0];
        end
        else
        begin
          quotient <= negQ_reg ? -{num_reg[WIDTH-2:0], 1'b0}
                               : {num_reg[WIDTH-2:0], 1'b0};
          remainder <= negR_reg ? -{rem_reg[WIDTH-2:0], num_reg[2*WIDTH-1]}
                                : {rem_reg[WIDTH-2:0], num_reg[2*WIDTH-1]};
        end
      end
    end
  end
endmodule : sxd_divider

// ---- design/sxd_datapath.sv ----
`timescale 1ns/1ps
module sxd_datapath (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reqValid,
  input wire sxd_pkg::sxd_req_t req,
  output logic reqReady,
  output logic opDone,
  output logic [31:0] result,
  output logic [31:0] resultHigh,
  output logic resultWr,
  output logic [2:0] resultSel,
  output sxd_pkg::sxd_flags_t flags,
  output sxd_pkg::sxd_mem_t mem,
  input wire logic [31:0] memRdData,
  output logic [31:0] gprOut [8],
  input wire logic gprLoad,
  input wire logic [2:0] gprLoadSel,
  input wire logic [31:0] gprLoadData
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PUSHALL = 5'b00010,
    ST_POPALL = 5'b00100,
    ST_DIV = 5'b01000,
    ST_DONE = 5'b10000
  } sxd_state_t;

  sxd_state_t state_reg;
  logic [31:0] gpr_reg [8];
  logic [2:0] slot_reg;
  logic [31:0] spSave_reg;
  logic addr32_reg;
  logic [2:0] divSel_reg;
  sxd_pkg::sxd_size_t divSize_reg;
  logic popWr_reg;
  logic [2:0] popSlot_reg;
  logic popA32_reg;
  logic [31:0] popData;
  logic accept;
  logic divStart;
  logic divBusy;
  logic divDone;
  logic [31:0] divQ;
  logic [31:0] divR;
  logic [63:0] dividend;
  logic [31:0] divisor;

  // Width mask, sign bit and sign/zero extension helpers
  function automatic logic [31:0] sxd_mask(input sxd_pkg::sxd_size_t s);
    case (s)
      sxd_pkg::SZ_BYTE: sxd_mask = 32'h0000_00FF;
      sxd_pkg::SZ_WORD: sxd_mask = 32'h0000_FFFF;
      default: sxd_mask = 32'hFFFF_FFFF;
    endcase
  endfunction : sxd_mask

  function automatic logic sxd_msb(input logic [31:0] v,
                                   input sxd_pkg::sxd_size_t s);
    case (s)
      sxd_pkg::SZ_BYTE: sxd_msb = v[7];
      sxd_pkg::SZ_WORD: sxd_msb = v[15];
      default: sxd_msb = v[31];
    endcase
  endfunction : sxd_msb

  function automatic logic [31:0] sxd_ext(input logic [31:0] v,
                                          input sxd_pkg::sxd_size_t s,
                                          input logic sgn);
    sxd_ext = (v & sxd_mask(s)) | ((sgn && sxd_msb(v, s)) ? ~sxd_mask(s)
                                                          : 32'h0000_0000);
  endfunction : sxd_ext

  function automatic logic [31:0] sxd_step(input logic a32);
    sxd_step = a32 ? sxd_pkg::STEP_DWORD : sxd_pkg::STEP_WORD;
  endfunction : sxd_step

  assign reqReady = (state_reg == ST_IDLE);
  assign accept = reqValid && reqReady;
  assign gprOut = gpr_reg;

  // Arithmetic: one adder serves add/sub/inc/dec/cmp/neg
  logic [31:0] a;
  logic [31:0] b;
  logic [32:0] sum;
  logic cin;
  logic isSub;
  logic [31:0] arith;
  sxd_pkg::sxd_flags_t arithFlags;
  logic [63:0] prod;
  logic [7:0] al;
  logic [7:0] bcdVal;
  logic bcdCarry;
  logic bcdAux;

  always_comb
  begin
    a = req.opA & sxd_mask(req.size);
    b = req.opB & sxd_mask(req.size);
    cin = 1'b0;
    isSub = 1'b0;
    case (req.op)
      sxd_pkg::OP_ADC: cin = flags.carry;
      sxd_pkg::OP_SUB, sxd_pkg::OP_CMP: isSub = 1'b1;
      sxd_pkg::OP_SBB:
      begin
        isSub = 1'b1;
        cin = flags.carry;
      end
      sxd_pkg::OP_INC: b = 32'h0000_0001;
      sxd_pkg::OP_DEC:
      begin
        isSub = 1'b1;
        b = 32'h0000_0001;
      end
      sxd_pkg::OP_NEG:
      begin
        isSub = 1'b1;
        b = a;
        a = 32'h0000_0000;
      end
      default: ;
    endcase
    sum = isSub ? ({1'b0, a} - {1'b0, b} - {32'h0, cin})
                : ({1'b0, a} + {1'b0, b} + {32'h0, cin});
    arith = sum[31:0] & sxd_mask(req.size);
    arithFlags.zero = (arith == 32'h0000_0000);
    arithFlags.sign = sxd_msb(arith, req.size);
    arithFlags.parity = ~^arith[7:0];
    arithFlags.auxCarry = a[4] ^ b[4] ^ arith[4];
    arithFlags.overflow = (sxd_msb(a, req.size) ^ sxd_msb(arith, req.size))
                          & (sxd_msb(a, req.size) ^ sxd_msb(b, req.size)
                             ^ ~isSub);
    case (req.size)
      sxd_pkg::SZ_BYTE: arithFlags.carry = a[8] ^ b[8] ^ sum[8];
      sxd_pkg::SZ_WORD: arithFlags.carry = a[16] ^ b[16] ^ sum[16];
      default: arithFlags.carry = sum[32];
    endcase
    // Double-width product; signed form extends both sources
    prod = req.op == sxd_pkg::OP_SMUL
         ? 64'($signed({{32{sxd_msb(req.opA, req.size)}},
                        sxd_ext(req.opA, req.size, 1'b1)})
               * $signed({{32{sxd_msb(req.opB, req.size)}},
                          sxd_ext(req.opB, req.size, 1'b1)}))
         : 64'({32'h0, a} * {32'h0, b});
    // Packed decimal adjust of the accumulator low byte
    al = gpr_reg[sxd_pkg::GPR_ACC][7:0];
    bcdVal = al;
    bcdCarry = 1'b0;
    bcdAux = 1'b0;
    if (al[3:0] > sxd_pkg::BCD_DIGIT_LIM || flags.auxCarry)
    begin
      bcdVal = (req.op == sxd_pkg::OP_BCDSUB) ? al - sxd_pkg::BCD_LOW_FIX
                                              : al + sxd_pkg::BCD_LOW_FIX;
      bcdAux = 1'b1;
    end
    if (al > sxd_pkg::BCD_HIGH_LIM || flags.carry)
    begin
      bcdVal = (req.op == sxd_pkg::OP_BCDSUB)
             ? bcdVal - sxd_pkg::BCD_HIGH_FIX
             : bcdVal + sxd_pkg::BCD_HIGH_FIX;
      bcdCarry = 1'b1;
    end
  end

  // Sequencer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      slot_reg <= 3'h0;
      addr32_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (accept)
          begin
            slot_reg <= 3'h0;
            addr32_reg <= req.addr32;
            case (req.op)
              sxd_pkg::OP_PUSHALL: state_reg <= ST_PUSHALL;
              sxd_pkg::OP_POPALL: state_reg <= ST_POPALL;
              sxd_pkg::OP_UDIV, sxd_pkg::OP_SDIV: state_reg <= ST_DIV;
              default: state_reg <= ST_IDLE;
            endcase
          end
        ST_PUSHALL, ST_POPALL:
        begin
          slot_reg <= slot_reg + 3'h1;
          if (slot_reg == sxd_pkg::SLOT_LAST)
            state_reg <= ST_IDLE;
        end
        ST_DIV:
          if (divDone)
            state_reg <= ST_DONE;
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign divStart = accept && (req.op == sxd_pkg::OP_UDIV
                               || req.op == sxd_pkg::OP_SDIV);
  always_comb
  begin
    // Dividend is data_ext:accumulator at word and dword width; byte form divides the accumulator low word
    case (req.size)
      sxd_pkg::SZ_BYTE:
        dividend = 64'(sxd_ext(gpr_reg[sxd_pkg::GPR_ACC], sxd_pkg::SZ_WORD,
                               req.op == sxd_pkg::OP_SDIV));
      sxd_pkg::SZ_WORD:
        dividend = 64'(sxd_ext({gpr_reg[sxd_pkg::GPR_DAT][15:0],
                                gpr_reg[sxd_pkg::GPR_ACC][15:0]},
                               sxd_pkg::SZ_DWORD, 1'b0))
                 | ((req.op == sxd_pkg::OP_SDIV
                     && gpr_reg[sxd_pkg::GPR_DAT][15])
                    ? 64'hFFFF_FFFF_0000_0000 : 64'h0);
      default:
        dividend = {gpr_reg[sxd_pkg::GPR_DAT], gpr_reg[sxd_pkg::GPR_ACC]};
    endcase
    divisor = sxd_ext(req.opB, req.size, 1'b1);
    if (req.size == sxd_pkg::SZ_DWORD)
      divisor = req.opB;
    else if (req.op != sxd_pkg::OP_SDIV)
      divisor = req.opB & sxd_mask(req.size);
  end

  sxd_divider #(
    .WIDTH(32)
  ) u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(divStart),
    .signedMode(req.op == sxd_pkg::OP_SDIV),
    .dividend(dividend),
    .divisor(divisor),
    .busy(divBusy),
    .done(divDone),
    .quotient(divQ),
    .remainder(divR)
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      divSel_reg <= 3'h0;
      divSize_reg <= sxd_pkg::SZ_DWORD;
    end
    else if (divStart)
    begin
      divSel_reg <= req.dstSel;
      divSize_reg <= req.size;
    end
  end

  // Stack memory port and register file
  always_ff @(posedge clk_sys)
  begin
    mem.wrEn <= 1'b0;
    mem.rdEn <= 1'b0;
    opDone <= 1'b0;
    resultWr <= 1'b0;
    if (rst)
    begin
      mem <= '0;
      result <= 32'h0000_0000;
      resultHigh <= 32'h0000_0000;
      resultSel <= 3'h0;
      flags <= '0;
      spSave_reg <= sxd_pkg::SP_RESET;
      for (int i = 0; i < sxd_pkg::NUM_GPR; i++)
        gpr_reg[i] <= 32'h0000_0000;
    end
    else
    begin
      if (gprLoad && state_reg == ST_IDLE)
        gpr_reg[gprLoadSel] <= gprLoadData;
      if (accept)
      begin
        opDone <= !(req.op inside {sxd_pkg::OP_PUSHALL, sxd_pkg::OP_POPALL,
                                   sxd_pkg::OP_UDIV, sxd_pkg::OP_SDIV});
        resultSel <= req.dstSel;
        case (req.op)
          sxd_pkg::OP_PUSH:
          begin
            // Operand already fetched: any source kind works
            gpr_reg[sxd_pkg::GPR_STK] <= gpr_reg[sxd_pkg::GPR_STK]
                                         - sxd_step(req.addr32);
            mem.addr <= gpr_reg[sxd_pkg::GPR_STK] - sxd_step(req.addr32);
            mem.wrData <= req.opA;
            mem.wrEn <= 1'b1;
          end
          sxd_pkg::OP_POP:
          begin
            mem.addr <= gpr_reg[sxd_pkg::GPR_STK];
            mem.rdEn <= 1'b1;
            gpr_reg[sxd_pkg::GPR_STK] <= gpr_reg[sxd_pkg::GPR_STK]
                                         + sxd_step(req.addr32);
          end
          sxd_pkg::OP_PUSHALL: spSave_reg <= gpr_reg[sxd_pkg::GPR_STK];
          sxd_pkg::OP_CBW:
            gpr_reg[sxd_pkg::GPR_ACC][15:8] <=
              {8{gpr_reg[sxd_pkg::GPR_ACC][7]}};
          sxd_pkg::OP_WORD_TO_DWORD_EXT:
            gpr_reg[sxd_pkg::GPR_ACC][31:16] <=
              {16{gpr_reg[sxd_pkg::GPR_ACC][15]}};
          sxd_pkg::OP_CWDPAIR:
            gpr_reg[sxd_pkg::GPR_DAT][15:0] <=
              {16{gpr_reg[sxd_pkg::GPR_ACC][15]}};
          sxd_pkg::OP_CDQPAIR:
            gpr_reg[sxd_pkg::GPR_DAT] <=
              {32{gpr_reg[sxd_pkg::GPR_ACC][31]}};
          sxd_pkg::OP_MOVSEXT, sxd_pkg::OP_MOVZEXT:
          begin
            result <= sxd_ext(req.opA, req.srcSize,
                              req.op == sxd_pkg::OP_MOVSEXT)
                      & sxd_mask(req.size);
            resultWr <= 1'b1;
          end
          sxd_pkg::OP_ADD, sxd_pkg::OP_ADC, sxd_pkg::OP_SUB, sxd_pkg::OP_SBB,
          sxd_pkg::OP_INC, sxd_pkg::OP_DEC, sxd_pkg::OP_NEG:
          begin
            result <= arith;
            resultWr <= 1'b1;
            flags <= arithFlags;
            // Increment and decrement keep the carry
            if (req.op inside {sxd_pkg::OP_INC, sxd_pkg::OP_DEC})
              flags.carry <= flags.carry;
          end
          sxd_pkg::OP_CMP: flags <= arithFlags;
          sxd_pkg::OP_UMUL, sxd_pkg::OP_SMUL:
          begin
            // Both forms write the low half to result and the high half to resultHigh
            result <= prod[31:0] & sxd_mask(req.size);
            case (req.size)
              sxd_pkg::SZ_BYTE: resultHigh <= {24'h0, prod[15:8]};
              sxd_pkg::SZ_WORD: resultHigh <= {16'h0, prod[31:16]};
              default: resultHigh <= prod[63:32];
            endcase
            resultWr <= 1'b1;
          end
          sxd_pkg::OP_BCDADD, sxd_pkg::OP_BCDSUB:
          begin
            gpr_reg[sxd_pkg::GPR_ACC][7:0] <= bcdVal;
            flags.carry <= bcdCarry;
            flags.auxCarry <= bcdAux;
            flags.zero <= (bcdVal == 8'h00);
            flags.sign <= bcdVal[7];
            flags.parity <= ~^bcdVal;
          end
          default: ;
        endcase
      end
      if (state_reg == ST_PUSHALL)
      begin
        // Pointer-slot stores the value saved before the first store
        gpr_reg[sxd_pkg::GPR_STK] <= gpr_reg[sxd_pkg::GPR_STK]
                                     - sxd_step(addr32_reg);
        mem.addr <= gpr_reg[sxd_pkg::GPR_STK] - sxd_step(addr32_reg);
        mem.wrData <= (slot_reg == sxd_pkg::GPR_STK) ? spSave_reg
                                                     : gpr_reg[slot_reg];
        mem.wrEn <= 1'b1;
        opDone <= (slot_reg == sxd_pkg::SLOT_LAST);
      end
      if (state_reg == ST_POPALL)
      begin
        mem.addr <= gpr_reg[sxd_pkg::GPR_STK];
        mem.rdEn <= 1'b1;
        gpr_reg[sxd_pkg::GPR_STK] <= gpr_reg[sxd_pkg::GPR_STK]
                                     + sxd_step(addr32_reg);
        opDone <= (slot_reg == sxd_pkg::SLOT_LAST);
      end
      if (state_reg == ST_DIV && divDone)
      begin
        result <= divQ & sxd_mask(divSize_reg);
        resultHigh <= divR & sxd_mask(divSize_reg);
        resultSel <= divSel_reg;
        resultWr <= 1'b1;
        opDone <= 1'b1;
      end
      // Pop-all load lands the cycle after its read; pointer slot skipped
      if (popWr_reg && popSlot_reg != sxd_pkg::GPR_STK)
        gpr_reg[popSlot_reg] <= popData;
    end
  end

  // Pop-all load: one cycle after the read, from the reversed slot
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      popWr_reg <= 1'b0;
      popSlot_reg <= 3'h0;
      popA32_reg <= 1'b0;
    end
    else
    begin
      popWr_reg <= (state_reg == ST_POPALL);
      popSlot_reg <= sxd_pkg::SLOT_LAST - slot_reg;
      popA32_reg <= addr32_reg;
    end
  end

  // Word form keeps the upper half of each register
  assign popData = popA32_reg ? memRdData
                 : {gpr_reg[popSlot_reg][31:16], memRdData[15:0]};
endmodule : sxd_datapath

// ---- verif/sxd_chk.sv ----
`timescale 1ns/1ps
module sxd_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reqValid,
  input wire sxd_pkg::sxd_req_t req,
  input wire logic reqReady,
  input wire logic opDone,
  input wire logic [31:0] result,
  input wire logic resultWr,
  input wire sxd_pkg::sxd_flags_t flags,
  input wire sxd_pkg::sxd_mem_t mem,
  input wire logic [31:0] gprOut [8]
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic tk;
  logic d32;
  sxd_pkg::sxd_op_t lastOp;
  assign tk = reqValid && reqReady && req.addr32;
  assign d32 = req.size == sxd_pkg::SZ_DWORD;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      lastOp <= sxd_pkg::OP_NOP;
    else if (reqValid && reqReady)
      lastOp <= req.op;
  end
  a_push_store: assert property (
    tk && d32 && req.op == sxd_pkg::OP_PUSH |=> mem.wrEn
    && gprOut[4] == mem.addr && mem.wrData == $past(req.opA)
    && mem.addr == $past(gprOut[4]) - sxd_pkg::STEP_DWORD)
    else $error("push store misplaced");
  a_pop_read: assert property (
    tk && req.op == sxd_pkg::OP_POP |=> mem.rdEn
    && mem.addr == $past(gprOut[4])
    && gprOut[4] == $past(gprOut[4]) + sxd_pkg::STEP_DWORD)
    else $error("pop read misplaced");
  a_pushall_first: assert property (
    tk && req.op == sxd_pkg::OP_PUSHALL
    |-> ##[1:3] (mem.wrEn && mem.wrData == gprOut[0]))
    else $error("push all first store wrong");
  a_popall_no_write: assert property (
    lastOp == sxd_pkg::OP_POPALL && !reqReady |-> !mem.wrEn)
    else $error("store during pop all");
  a_adc_sum: assert property (
    tk && d32 && req.op == sxd_pkg::OP_ADC |=> resultWr && result ==
    $past(req.opA) + $past(req.opB) + {31'h0, $past(flags.carry)})
    else $error("add with carry wrong");
  a_sbb_diff: assert property (
    tk && d32 && req.op == sxd_pkg::OP_SBB |=> resultWr && result ==
    $past(req.opA) - $past(req.opB) - {31'h0, $past(flags.carry)})
    else $error("subtract with borrow wrong");
  a_cmp_no_store: assert property (
    tk && d32 && req.op == sxd_pkg::OP_CMP |=> opDone && !resultWr
    && flags.zero == ($past(req.opA) == $past(req.opB)))
    else $error("compare stored a result");
  a_neg_zero_minus: assert property (
    tk && d32 && req.op == sxd_pkg::OP_NEG
    |=> resultWr && result == 32'h0 - $past(req.opA))
    else $error("negate wrong");
  c_popall: cover property (tk && req.op == sxd_pkg::OP_POPALL);
  c_pushall: cover property (tk && req.op == sxd_pkg::OP_PUSHALL);
  c_bcd: cover property (tk && req.op == sxd_pkg::OP_BCDSUB);
endmodule : sxd_chk

bind sxd_datapath sxd_chk chk_u (.clk_sys, .rst, .reqValid, .req,
  .reqReady, .opDone, .result, .resultWr, .flags, .mem, .gprOut);

// ---- verif/sxd_mem_model.sv ----
`timescale 1ns/1ps
module sxd_mem_model (
  input wire logic clk_sys,
  input wire sxd_pkg::sxd_mem_t mem,
  output logic [31:0] memRdData
);
  // Only a 512-byte window; wider stacks alias
  logic [31:0] cells [256];
  logic [31:0] lastRd = 32'h0;
  // Data stands in the rdEn cycle; idle bus shows the inverse of the last
  always_comb
    memRdData = mem.rdEn ? cells[mem.addr[8:1]] : ~lastRd;
  always @(posedge clk_sys)
  begin
    if (mem.wrEn)
      cells[mem.addr[8:1]] <= mem.wrData;
    if (mem.rdEn)
      lastRd <= memRdData;
  end
endmodule : sxd_mem_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  localparam sxd_pkg::sxd_size_t B = sxd_pkg::SZ_BYTE;
  localparam sxd_pkg::sxd_size_t W = sxd_pkg::SZ_WORD;
  localparam sxd_pkg::sxd_size_t D = sxd_pkg::SZ_DWORD;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  sxd_pkg::sxd_req_t req = '0;
  logic gprLoad = 1'b0;
  logic [2:0] gprLoadSel = 3'h0;
  logic [31:0] gprLoadData = 32'h0;
  logic reqReady, opDone, resultWr;
  logic [31:0] result, resultHigh, memRdData;
  logic [2:0] resultSel;
  sxd_pkg::sxd_flags_t flags;
  sxd_pkg::sxd_mem_t mem;
  logic [31:0] gprOut [8];
  int errors = 0;
  int num_checks = 0;

  sxd_datapath dut_u (.clk_sys, .rst, .reqValid, .req, .reqReady,
    .opDone, .result, .resultHigh, .resultWr, .resultSel, .flags,
    .mem, .memRdData, .gprOut, .gprLoad, .gprLoadSel, .gprLoadData);
  sxd_mem_model mem_u (.clk_sys, .mem, .memRdData);

  always #25 clk_sys = ~clk_sys;

  task complete_run;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Leaves the load strobe up; run drops it, avoiding a double drive
  task ld(input logic [2:0] sel, input logic [31:0] d);
    gprLoad = 1'b1;
    gprLoadSel = sel;
    gprLoadData = d;
    @(negedge clk_sys);
  endtask : ld

  task run(input sxd_pkg::sxd_op_t op, input sxd_pkg::sxd_size_t sz,
    input sxd_pkg::sxd_size_t ss, input logic a32,
    input logic [31:0] a, input logic [31:0] b);
    int n;
    gprLoad = 1'b0;
    for (n = 0; n < 200 && reqReady !== 1'b1; n++)
      @(negedge clk_sys);
    req = '{op, sz, ss, a32, 1'b0, 3'(op), a, b};
    reqValid = 1'b1;
    @(negedge clk_sys);
    reqValid = 1'b0;
    for (n = 0; n < 200 && opDone !== 1'b1; n++)
      @(negedge clk_sys);
    chk({31'h0, opDone}, 32'h1);
    chk({29'h0, resultSel}, {29'h0, 3'(op)});
    @(negedge clk_sys);
  endtask : run

  task ex(input sxd_pkg::sxd_op_t op, input sxd_pkg::sxd_size_t sz,
    input sxd_pkg::sxd_size_t ss, input logic [31:0] a,
    input logic [31:0] b, input logic [31:0] exp);
    run(op, sz, ss, 1'b1, a, b);
    chk(result, exp);
  endtask : ex

  task t_stack;
    ld(3'h4, 32'h200);
    run(sxd_pkg::OP_PUSH, D, D, 1'b1, 32'hCAFE0001, 32'h0);
    chk(gprOut[4], 32'h1FC);
    run(sxd_pkg::OP_POP, D, D, 1'b1, 32'h0, 32'h0);
    chk(gprOut[4], 32'h200);
  endtask : t_stack

  task t_all(input logic a32);
    logic [31:0] v [8];
    for (int i = 0; i < 8; i++)
    begin
      v[i] = (i == 4) ? 32'h300 : 32'hA5A50000 | (i * 32'h111);
      ld(i[2:0], v[i]);
    end
    run(sxd_pkg::OP_PUSHALL, D, D, a32, 32'h0, 32'h0);
    chk(gprOut[4], a32 ? 32'h2E0 : 32'h2F0);
    for (int i = 0; i < 8; i++)
      if (i != 4)
        ld(i[2:0], 32'h5A5AFFFF);
    run(sxd_pkg::OP_POPALL, D, D, a32, 32'h0, 32'h0);
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < 8; i++)
      chk(gprOut[i], (a32 || i == 4) ? v[i] : {16'h5A5A, v[i][15:0]});
    chk(gprOut[4], 32'h300);
  endtask : t_all

  task t_ext;
    ld(3'h0, 32'h80);
    run(sxd_pkg::OP_CBW, W, W, 1'b1, 32'h0, 32'h0);
    chk(gprOut[0], 32'hFF80);
    ld(3'h0, 32'h8000);
    run(sxd_pkg::OP_WORD_TO_DWORD_EXT, D, W, 1'b1, 32'h0, 32'h0);
    chk(gprOut[0], 32'hFFFF8000);
    ld(3'h0, 32'h8000);
    ld(3'h2, 32'h0);
    run(sxd_pkg::OP_CWDPAIR, W, W, 1'b1, 32'h0, 32'h0);
    chk(gprOut[2], 32'hFFFF);
    ld(3'h0, 32'h80000000);
    run(sxd_pkg::OP_CDQPAIR, D, D, 1'b1, 32'h0, 32'h0);
    chk(gprOut[2], 32'hFFFFFFFF);
    ex(sxd_pkg::OP_MOVSEXT, D, B, 32'h80, 32'h0, 32'hFFFFFF80);
    ex(sxd_pkg::OP_MOVSEXT, W, B, 32'hF0, 32'h0, 32'hFFF0);
    ex(sxd_pkg::OP_MOVZEXT, D, W, 32'hFFFF8001, 0, 32'h8001);
  endtask : t_ext

  task t_arith;
    ex(sxd_pkg::OP_ADD, D, D, 32'hFFFFFFFF, 32'h1, 32'h0);
    chk({26'h0, flags}, 32'h3C);
    ex(sxd_pkg::OP_ADC, D, D, 32'h5, 32'h6, 32'hC);
    ex(sxd_pkg::OP_ADC, D, D, 32'h5, 32'h6, 32'hB);
    ex(sxd_pkg::OP_SUB, B, B, 32'h1, 32'h2, 32'hFF);
    ex(sxd_pkg::OP_SBB, D, D, 32'hA, 32'h3, 32'h6);
    ex(sxd_pkg::OP_SBB, D, D, 32'hA, 32'h3, 32'h7);
    ex(sxd_pkg::OP_INC, W, W, 32'hFFFF, 32'h0, 32'h0);
    ex(sxd_pkg::OP_DEC, D, D, 32'h0, 32'h0, 32'hFFFFFFFF);
    ex(sxd_pkg::OP_NEG, D, D, 32'h1, 32'h0, 32'hFFFFFFFF);
    run(sxd_pkg::OP_CMP, D, D, 1'b1, 32'h7, 32'h7);
    chk({26'h0, flags}, 32'h14);
    run(sxd_pkg::OP_CMP, D, D, 1'b1, 32'h3, 32'h7);
    chk({26'h0, flags}, 32'h3A);
  endtask : t_arith

  task t_muldiv;
    ex(sxd_pkg::OP_UMUL, D, D, 32'hFFFFFFFF, 32'h2, 32'hFFFFFFFE);
    chk(resultHigh, 32'h1);
    ex(sxd_pkg::OP_SMUL, D, D, 32'hFFFFFFFE, 32'h3, 32'hFFFFFFFA);
    chk(resultHigh, 32'hFFFFFFFF);
    ld(3'h2, 32'h0);
    ld(3'h0, 32'h64);
    ex(sxd_pkg::OP_UDIV, D, D, 32'h64, 32'h7, 32'hE);
    chk(resultHigh, 32'h2);
    ld(3'h2, 32'hFFFFFFFF);
    ld(3'h0, 32'hFFFFFF9C);
    ex(sxd_pkg::OP_SDIV, D, D, 32'hFFFFFF9C, 32'h7, 32'hFFFFFFF2);
    chk(resultHigh, 32'hFFFFFFFE);
  endtask : t_muldiv

  task t_bcd;
    ex(sxd_pkg::OP_ADD, B, B, 32'h38, 32'h45, 32'h7D);
    ld(3'h0, 32'h7D);
    run(sxd_pkg::OP_BCDADD, B, B, 1'b1, 32'h0, 32'h0);
    chk({24'h0, gprOut[0][7:0]}, 32'h83);
    chk({31'h0, flags.carry}, 32'h0);
    ex(sxd_pkg::OP_ADD, B, B, 32'h99, 32'h1, 32'h9A);
    ld(3'h0, 32'h9A);
    run(sxd_pkg::OP_BCDADD, B, B, 1'b1, 32'h0, 32'h0);
    chk({24'h0, gprOut[0][7:0]}, 32'h0);
    chk({31'h0, flags.carry}, 32'h1);
    ex(sxd_pkg::OP_SUB, B, B, 32'h12, 32'h29, 32'hE9);
    ld(3'h0, 32'hE9);
    run(sxd_pkg::OP_BCDSUB, B, B, 1'b1, 32'h0, 32'h0);
    chk({24'h0, gprOut[0][7:0]}, 32'h83);
    chk({31'h0, flags.carry}, 32'h1);
  endtask : t_bcd

  initial
  begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    t_stack;
    t_all(1'b1);
    t_all(1'b0);
    t_ext;
    t_arith;
    t_muldiv;
    t_bcd;
    complete_run;
  end

  // Some twenty thousand cycles, far beyond the expected run
  initial
  begin
    #1000000;
    errors++;
    complete_run;
  end
endmodule : tb_top
